/* shared/ogm_map.svh */
`ifndef OGM_MAP_SVH
`define OGM_MAP_SVH

// Register indices; byte address is four times the index
`define OGM_IDX_LEFT_HEADPHONE_GAIN_MUTE 8'h10
`define OGM_IDX_RIGHT_HEADPHONE_GAIN_MUTE 8'h11
`define OGM_IDX_LEFT_LINEOUT_GAIN_MUTE 8'h12
`define OGM_IDX_RIGHT_LINEOUT_GAIN_MUTE 8'h13

// Field positions inside each driver register
`define OGM_RESERVED_BIT 7
`define OGM_MUTE_BIT 6
`define OGM_GAIN_MSB 5
`define OGM_GAIN_LSB 0

// Reset values
`define OGM_MUTE_RESET 1'h1
`define OGM_GAIN_RESET 6'h00

// Gain codes
`define OGM_GAIN_MINUS6DB 6'h3A
`define OGM_GAIN_RSV_NEG_LO 6'h20
`define OGM_GAIN_RSV_NEG_HI 6'h39
`define OGM_GAIN_RSV_POS_LO 6'h1E
`define OGM_GAIN_RSV_POS_HI 6'h1F

`endif

/* shared/ogm_pkg.sv */
package ogm_pkg;

	localparam int OGM_DRIVERS = 4;
	localparam int OGM_HEADPHONES = 2;

	typedef logic [5:0] ogm_gain_t;

	typedef struct packed {
		logic [OGM_DRIVERS-1:0] mute;
		logic [OGM_DRIVERS-1:0][5:0] gain;
		logic ack;
		logic [31:0] readdata;
		logic [OGM_HEADPHONES-1:0] sync1;
		logic [OGM_HEADPHONES-1:0] sync2;
		logic [OGM_HEADPHONES-1:0] sync3;
		logic [OGM_HEADPHONES-1:0] class_d;
		logic [OGM_DRIVERS-1:0] drv_mute;
		logic [OGM_DRIVERS-1:0][5:0] drv_gain;
		logic [OGM_DRIVERS-1:0] drv_gain_valid;
	} ogm_state_t;

endpackage : ogm_pkg

/* hw/ogm_regs.sv */
// Notes on behaviour
// RULE1 - Top bit reserved, reads zero, ignored on write
// RULE2 - Mute bit set silences driver, resets set
// RULE3 - Six-bit two's-complement gain, 1 dB steps, resets 0
// RULE4 - Software avoids reserved gain codes
// RULE5 - Headphone mute ignored at the -6 dB code
// RULE6 - Headphone gain undefined in Class-D mode
// RULE7 - Reads return last written mute and gain
`timescale 1ns/100ps
`default_nettype none
`include "ogm_map.svh"

module ogm_regs (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [7:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] writedata_i,
	input wire logic [3:0] byteenable_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic [ogm_pkg::OGM_HEADPHONES-1:0] class_d_i,
	output logic [ogm_pkg::OGM_DRIVERS-1:0] drv_mute_o,
	output logic [ogm_pkg::OGM_DRIVERS-1:0][5:0] drv_gain_o,
	output logic [ogm_pkg::OGM_DRIVERS-1:0] drv_gain_valid_o
);
	import ogm_pkg::*;

	ogm_state_t state;
	ogm_state_t next_state;

	// Byte address of a register index; indices count words
	function automatic logic [7:0] reg_address(input logic [7:0] idx);
		return 8'(idx << 2);
	endfunction : reg_address

	// Driver number of a byte address, or 4 when no driver register is hit
	function automatic logic [2:0] decode(input logic [7:0] addr);
		logic [2:0] hit;
		hit = 3'h4;
		if (addr == reg_address(`OGM_IDX_LEFT_HEADPHONE_GAIN_MUTE)) begin
			hit = 3'h0;
		end else if (addr == reg_address(`OGM_IDX_RIGHT_HEADPHONE_GAIN_MUTE)) begin
			hit = 3'h1;
		end else if (addr == reg_address(`OGM_IDX_LEFT_LINEOUT_GAIN_MUTE)) begin
			hit = 3'h2;
		end else if (addr == reg_address(`OGM_IDX_RIGHT_LINEOUT_GAIN_MUTE)) begin
			hit = 3'h3;
		end
		return hit;
	endfunction : decode

	function automatic logic gain_reserved(input ogm_gain_t g);
		return ((g >= `OGM_GAIN_RSV_NEG_LO) && (g <= `OGM_GAIN_RSV_NEG_HI)) ||
			((g >= `OGM_GAIN_RSV_POS_LO) && (g <= `OGM_GAIN_RSV_POS_HI)); // RULE4
	endfunction : gain_reserved

	// Headphone drivers occupy the low indices
	function automatic logic is_headphone(input int idx);
		logic hp;
		hp = 1'b0;
		if (idx < OGM_HEADPHONES) begin
			hp = 1'b1;
		end
		return hp;
	endfunction : is_headphone

	// Register image as software sees it
	function automatic logic [7:0] pack_register(input logic mute, input ogm_gain_t gain);
		logic [7:0] image;
		image = 8'h00;
		image[`OGM_RESERVED_BIT] = 1'b0; // RULE1
		image[`OGM_MUTE_BIT] = mute; // RULE7
		image[`OGM_GAIN_MSB:`OGM_GAIN_LSB] = gain; // RULE7
		return image;
	endfunction : pack_register

	// Mute as the driver obeys it; headphones cannot be muted at the -6 dB code
	function automatic logic effective_mute(input int idx, input logic mute, input ogm_gain_t gain);
		logic result;
		result = mute; // RULE2
		if (is_headphone(idx)) begin
			if (gain == `OGM_GAIN_MINUS6DB) begin
				result = 1'b0; // RULE5
			end
		end
		return result;
	endfunction : effective_mute

	// Gain code is meaningful only outside the reserved ranges and, for headphones, out of Class-D
	function automatic logic gain_valid(input int idx, input ogm_gain_t gain, input logic class_d);
		logic result;
		result = !gain_reserved(gain);
		if (is_headphone(idx)) begin
			if (class_d) begin
				result = 1'b0; // RULE6
			end
		end
		return result;
	endfunction : gain_valid

	// Byte-lane-0 write that hits a driver register
	function automatic logic write_hits(input logic wr, input logic [3:0] lanes, input logic [2:0] sel);
		logic hit;
		hit = wr && lanes[0];
		if (sel[2] != 1'b0) begin
			hit = 1'b0;
		end
		return hit;
	endfunction : write_hits

	// Driver registers sit in the low byte lane; upper lanes read zero
	function automatic logic [31:0] read_word(input logic [7:0] image);
		return {24'h000000, image};
	endfunction : read_word

	// Pin level accepted once the second and third stages agree
	function automatic logic [OGM_HEADPHONES-1:0] settle(
		input logic [OGM_HEADPHONES-1:0] held,
		input logic [OGM_HEADPHONES-1:0] stage2,
		input logic [OGM_HEADPHONES-1:0] stage3
	);
		logic [OGM_HEADPHONES-1:0] result;
		result = held;
		for (int i = 0; i < OGM_HEADPHONES; i++) begin
			if (stage2[i] == stage3[i]) begin
				result[i] = stage3[i];
			end
		end
		return result;
	endfunction : settle

	// Contents after reset: every driver muted at 0 dB, bus idle
	function automatic ogm_state_t reset_image();
		ogm_state_t img;
		img = '0;
		img.ack = 1'b0;
		img.readdata = 32'h00000000;
		img.sync1 = '0;
		img.sync2 = '0;
		img.sync3 = '0;
		img.class_d = '0;
		img.mute = {OGM_DRIVERS{`OGM_MUTE_RESET}}; // RULE2
		img.drv_mute = {OGM_DRIVERS{`OGM_MUTE_RESET}};
		img.drv_gain_valid = '1;
		for (int i = 0; i < OGM_DRIVERS; i++) begin
			img.gain[i] = `OGM_GAIN_RESET; // RULE3
			img.drv_gain[i] = `OGM_GAIN_RESET;
		end
		return img;
	endfunction : reset_image

	always_comb begin
		logic [2:0] sel;
		logic [7:0] rbyte;
		logic write_now;
		logic cd;
		sel = decode(address_i);
		rbyte = 8'h00;
		write_now = 1'b0;
		cd = 1'b0;
		next_state = state;

		// Pin synchroniser; class_d follows once stages two and three agree
		next_state.sync1 = class_d_i;
		next_state.sync2 = state.sync1;
		next_state.sync3 = state.sync2;
		next_state.class_d = settle(state.class_d, state.sync2, state.sync3);

		// Image of the addressed driver register, zero when unmapped
		if (sel[2] == 1'b0) begin
			rbyte = pack_register(state.mute[sel[1:0]], state.gain[sel[1:0]]); // RULE1 RULE7
		end else begin
			rbyte = 8'h00;
		end

		// One wait cycle, then answer; a write lands at the released edge
		if ((read_i || write_i) && !state.ack) begin
			next_state.ack = 1'b1;
			next_state.readdata = read_word(rbyte);
		end else if (state.ack) begin
			next_state.ack = 1'b0;
			write_now = write_hits(write_i, byteenable_i, sel);
		end

		// Reserved top bit is not stored
		if (write_now) begin
			next_state.mute[sel[1:0]] = writedata_i[`OGM_MUTE_BIT]; // RULE2
			next_state.gain[sel[1:0]] = writedata_i[`OGM_GAIN_MSB:`OGM_GAIN_LSB]; // RULE3
		end

		// Driver outputs follow the stored fields at the same edge as a write
		for (int i = 0; i < OGM_DRIVERS; i++) begin
			cd = 1'b0;
			if (i < OGM_HEADPHONES) begin
				cd = next_state.class_d[i];
			end
			next_state.drv_gain[i] = next_state.gain[i]; // RULE3
			next_state.drv_mute[i] = effective_mute(i, next_state.mute[i],
				next_state.gain[i]); // RULE5
			next_state.drv_gain_valid[i] = gain_valid(i, next_state.gain[i],
				cd); // RULE6
		end

		if (reset_i) begin
			next_state = reset_image(); // RULE2 RULE3
		end
	end

	always_ff @(posedge clock_i) begin
		state <= next_state;
	end

	assign readdata_o = state.readdata;
	assign waitrequest_o = !state.ack;
	assign drv_mute_o = state.drv_mute;
	assign drv_gain_o = state.drv_gain;
	assign drv_gain_valid_o = state.drv_gain_valid;

endmodule : ogm_regs
`default_nettype wire

/* testbench/ogm_regs_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module ogm_regs_chk (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [31:0] readdata_o,
	input wire logic waitrequest_o,
	input wire logic [1:0] class_d_i,
	input wire logic [3:0] drv_mute_o,
	input wire logic [3:0][5:0] drv_gain_o,
	input wire logic [3:0] drv_gain_valid_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	rsv_zero_a: assert property (readdata_o[31:7] == 25'h0) else $error("rsv");
	reset_mute_a: assert property ($fell(reset_i) |-> drv_mute_o == 4'hF && drv_gain_o == 24'h0)
		else $error("reset");
	one_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o ##1 waitrequest_o)
		else $error("answer");
	hp_audible_a: assert property (drv_gain_o[0] == 6'h3A |-> !drv_mute_o[0]) else $error("mute");
	hp_right_audible_a: assert property (drv_gain_o[1] == 6'h3A |-> !drv_mute_o[1]) else $error("mute r");
	class_d_a: assert property (class_d_i[0] [*7] |-> !drv_gain_valid_o[0]) else $error("cd");
endmodule : ogm_regs_chk
bind ogm_regs ogm_regs_chk u_chk (.*);
`default_nettype wire

/* testbench/ogm_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module ogm_regs_tb;
	logic clock_i = 0, reset_i = 1, read_i = 0, write_i = 0, waitrequest_o;
	logic [7:0] address_i = 8'h00;
	logic [31:0] writedata_i = 32'h0, readdata_o, q;
	logic [1:0] class_d_i = 2'h0;
	logic [3:0] byteenable_i = 4'hF;
	logic [3:0] drv_mute_o, drv_gain_valid_o;
	logic [3:0][5:0] drv_gain_o;
	int fail_count = 0, comparisons = 0;
	always #20 clock_i = ~clock_i;
	ogm_regs u_dut (
		.clock_i(clock_i),
		.reset_i(reset_i),
		.address_i(address_i),
		.read_i(read_i),
		.write_i(write_i),
		.writedata_i(writedata_i),
		.byteenable_i(byteenable_i),
		.readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o),
		.class_d_i(class_d_i),
		.drv_mute_o(drv_mute_o),
		.drv_gain_o(drv_gain_o),
		.drv_gain_valid_o(drv_gain_valid_o)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		address_i <= a;
		writedata_i <= d;
		write_i <= w;
		read_i <= !w;
		do begin
			@(posedge clock_i);
		end while (waitrequest_o !== 1'b0);
		q = readdata_o;
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask : acc
	task automatic give_verdict;
		$display("mismatches %0d of %0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			acc(0, 8'h40 + 8'(4 * i), 0);
			chk(q, 32'h40);
		end
		$display("reset test done");
		acc(1, 8'h40, 32'hFA);
		acc(1, 8'h48, 32'h7A);
		acc(1, 8'h44, 32'h1D);
		acc(0, 8'h40, 0);
		chk(q, 32'h7A);
		acc(0, 8'h44, 0);
		chk(q, 32'h1D);
		byteenable_i <= 4'hE;
		acc(1, 8'h44, 32'h40);
		byteenable_i <= 4'hF;
		acc(0, 8'h44, 0);
		chk(q, 32'h1D);
		acc(0, 8'h50, 0);
		chk(q, 32'h0);
		@(posedge clock_i);
		chk(drv_mute_o, 4'hC);
		chk(drv_gain_o[1], 6'h1D);
		class_d_i <= 2'h1;
		repeat (7) @(posedge clock_i);
		chk(drv_gain_valid_o, 4'hE);
		acc(1, 8'h44, 32'h7A);
		@(posedge clock_i);
		chk(drv_mute_o[1], 1'b0);
		chk(drv_gain_o[0], 6'h3A);
		$display("write test done");
		give_verdict();
	end
	initial begin
		repeat (3000) @(posedge clock_i);
		fail_count++;
		give_verdict();
	end
endmodule : ogm_regs_tb
`default_nettype wire
